/* File: design/csog_consts.vh */
// Constants for the capacitance converter control block
`ifndef CSOG_CONSTS_VH
`define CSOG_CONSTS_VH
// Bus target address
`define CSOG_DEV_ADDR 7'h50
// Register pointers
`define CSOG_REG_CONF1 8'h08
`define CSOG_REG_CONF4 8'h0B
`define CSOG_REG_OFFCAL 8'h0D
`define CSOG_REG_GAIN1 8'h11
`define CSOG_REG_GAIN4 8'h14
// Register array indices
`define CSOG_IDX_OFFCAL 4'h4
`define CSOG_IDX_GAIN1 4'h5
`define CSOG_IDX_NONE 4'hF
`define CSOG_NUM_REGS 9
// Configuration fields
`define CSOG_CHA_HI 15
`define CSOG_CHA_LO 13
`define CSOG_CHB_HI 12
`define CSOG_CHB_LO 10
`define CSOG_DAC_HI 9
`define CSOG_DAC_LO 5
`define CSOG_CHB_SE_A 3'h4
`define CSOG_CHB_SE_B 3'h7
// Reset values
`define CSOG_CONF_RST 16'h1000
`define CSOG_OFFCAL_RST 16'h0000
`define CSOG_PTR_RST 8'h08
// Datapath scaling, capacitance in femtofarads
`define CSOG_DAC_STEP_FF 17'h0_0C35
`define CSOG_SPAN_FF 39'h00_0000_3A98
`define CSOG_GAIN_SHIFT 14
// Timing
`define CSOG_CLK_PERIOD_NS 5
`define CSOG_SPIKE_NS 50
`define CSOG_FILT_CYC ((`CSOG_SPIKE_NS / `CSOG_CLK_PERIOD_NS) + 1)
`endif

/* File: design/csog_glitch_filter.v */
// Spike filter for one serial bus input
`timescale 1ns/100ps
`include "csog_consts.vh"
module csog_glitch_filter (
    input wire clk,
    input wire rst_n,
    input wire din,
    output reg dout_ff
);
    reg [3:0] cnt_ff;

    // Accept a new level only after it outlasts the spike width
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= 1'b1;
            cnt_ff <= 4'h0;
        end else if (din == dout_ff) begin
            cnt_ff <= 4'h0;
        end else if (cnt_ff == (`CSOG_FILT_CYC - 1)) begin // RULE13
            dout_ff <= din;
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule // csog_glitch_filter

/* File: design/csog_top.v */
// Shield routing, offset and gain control with two-wire register access
// What this block does
// RULE1: Differential mode drives shield one from the lower and shield two from the higher input.
// RULE2: Single-ended mode with the offset DAC off ties both shields together.
// RULE3: Single-ended mode with the offset DAC on drives shield one and floats shield two.
// RULE4: Each active shield copies the excitation of its associated input.
// RULE5: A single-ended result is the input capacitance minus the offset DAC capacitance.
// RULE6: The offset DAC takes a 5-bit code and its capacitance never falls as the code rises.
// RULE7: Results span plus or minus 15 pF over an offset of up to 100 pF.
// RULE8: The offset calibration register returns to its default on every reset.
// RULE9: The host removes large offset with the DAC and trims about 1 pF with offset calibration.
// RULE10: The host keeps and rewrites its offset calibration unless it recalibrates.
// RULE11: A factory gain from one-time storage is the default conversion gain.
// RULE12: Gain registers at 0x11 to 0x14 override gain until reset restores the factory value.
// RULE13: Bus input spikes of 50 ns or less are rejected.
// RULE14: Negative select codes 100 and 111 mean single-ended, codes below 100 differential.
// RULE15: The offset DAC code sits in bits 9 to 5 of each configuration register.
// RULE16: The offset DAC has no effect in a differential measurement.
// RULE17: Gain registers map in ascending address order to inputs one to four.
`timescale 1ns/100ps
`include "csog_consts.vh"
module csog_top (
    input wire SYS_CLK,
    input wire RSTN,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SDA_OUT,
    output reg SDA_OEN,
    input wire [15:0] OTP_GAIN,
    input wire [1:0] MEAS_SEL,
    input wire [3:0] EXC,
    output reg SHIELD1,
    output reg SHIELD2,
    output reg SHIELD2_OEN,
    output reg SHIELD_TIE,
    input wire CAP_VALID,
    input wire [19:0] CAP_POS,
    input wire [19:0] CAP_NEG,
    output reg RESULT_VALID,
    output reg [19:0] RESULT
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_PTR = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_ACK = 3'h4;
    localparam ST_READ = 3'h5;
    localparam ST_RACK = 3'h6;
    function [3:0] csog_reg_idx;
        input [7:0] ptr;
        begin
            csog_reg_idx = (ptr >= `CSOG_REG_CONF1 && ptr <= `CSOG_REG_CONF4) ? ptr[3:0] - 4'h8
                : (ptr == `CSOG_REG_OFFCAL) ? `CSOG_IDX_OFFCAL
                : (ptr >= `CSOG_REG_GAIN1 && ptr <= `CSOG_REG_GAIN4) ? ptr[3:0] + 4'h4 // RULE17
                : `CSOG_IDX_NONE;
        end
    endfunction
    reg rst_meta_ff;
    reg rst_sync_ff;
    always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire rst_n = rst_sync_ff;
    wire [1:0] pin_raw = {SDA_IN, SCL_IN};
    wire [1:0] pin_flt;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
            csog_glitch_filter u_filt (
                .clk(SYS_CLK),
                .rst_n(rst_n),
                .din(pin_raw[gi]),
                .dout_ff(pin_flt[gi])
            );
        end
    endgenerate
    wire scl = pin_flt[0];
    wire sda = pin_flt[1];
    reg scl_d_ff;
    reg sda_d_ff;
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
        end
    end
    wire bus_start = scl && scl_d_ff && sda_d_ff && !sda;
    wire bus_stop = scl && scl_d_ff && !sda_d_ff && sda;
    wire scl_rise = scl && !scl_d_ff;
    wire scl_fall = !scl && scl_d_ff;
    reg [15:0] regs_ff [0:`CSOG_NUM_REGS-1];
    reg load_otp_ff;
    reg wr_en_ff;
    reg [3:0] wr_idx_ff;
    reg [15:0] wr_data_ff;
    integer ri;
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            load_otp_ff <= 1'b1;
            for (ri = 0; ri < `CSOG_NUM_REGS; ri = ri + 1) begin
                regs_ff[ri] <= `CSOG_CONF_RST;
            end
            regs_ff[`CSOG_IDX_OFFCAL] <= `CSOG_OFFCAL_RST; // RULE8
        end else begin
            load_otp_ff <= 1'b0;
            if (load_otp_ff) begin
                for (ri = 0; ri < 4; ri = ri + 1) begin
                    regs_ff[`CSOG_IDX_GAIN1 + ri] <= OTP_GAIN; // RULE11 RULE12
                end
            end else if (wr_en_ff) begin
                regs_ff[wr_idx_ff] <= wr_data_ff; // RULE12
            end
        end
    end
    reg [2:0] state_ff;
    reg [2:0] ack_next_ff;
    reg [7:0] shift_ff;
    reg [3:0] bit_cnt_ff;
    reg byte_ix_ff;
    reg [7:0] ptr_ff;
    reg [7:0] wbuf_ff;
    wire [3:0] shift_idx = csog_reg_idx(shift_ff);
    wire [15:0] rd_word = regs_ff[csog_reg_idx(ptr_ff)];
    wire [7:0] rd_byte = byte_ix_ff ? rd_word[7:0] : rd_word[15:8];
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            ack_next_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bit_cnt_ff <= 4'h0;
            byte_ix_ff <= 1'b0;
            ptr_ff <= `CSOG_PTR_RST;
            wbuf_ff <= 8'h00;
            SDA_OUT <= 1'b0;
            SDA_OEN <= 1'b1;
            wr_en_ff <= 1'b0;
            wr_idx_ff <= 4'h0;
            wr_data_ff <= 16'h0000;
        end else begin
            wr_en_ff <= 1'b0;
            if (bus_start) begin
                state_ff <= ST_ADDR;
                bit_cnt_ff <= 4'h0;
                byte_ix_ff <= 1'b0;
                SDA_OEN <= 1'b1;
            end else if (bus_stop) begin
                state_ff <= ST_IDLE;
                SDA_OEN <= 1'b1;
            end else begin
                case (state_ff)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_ff <= {shift_ff[6:0], sda};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                            bit_cnt_ff <= 4'h0;
                            state_ff <= ST_ACK;
                            SDA_OEN <= 1'b0;
                            if (state_ff == ST_ADDR) begin
                                ack_next_ff <= shift_ff[0] ? ST_READ : ST_PTR;
                                if (shift_ff[7:1] != `CSOG_DEV_ADDR) begin
                                    state_ff <= ST_IDLE;
                                    SDA_OEN <= 1'b1;
                                end
                            end else if (state_ff == ST_PTR) begin
                                ack_next_ff <= ST_WDATA;
                                ptr_ff <= shift_ff;
                                if (shift_idx == `CSOG_IDX_NONE) begin
                                    state_ff <= ST_IDLE;
                                    SDA_OEN <= 1'b1;
                                    ptr_ff <= ptr_ff;
                                end
                            end else begin
                                byte_ix_ff <= ~byte_ix_ff;
                                if (!byte_ix_ff) begin
                                    wbuf_ff <= shift_ff;
                                end else begin
                                    wr_en_ff <= 1'b1;
                                    wr_idx_ff <= csog_reg_idx(ptr_ff);
                                    wr_data_ff <= {wbuf_ff, shift_ff};
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            state_ff <= ack_next_ff;
                            if (ack_next_ff == ST_READ) begin
                                shift_ff <= rd_byte;
                                SDA_OEN <= rd_byte[7];
                                bit_cnt_ff <= 4'h1;
                            end else begin
                                SDA_OEN <= 1'b1;
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            if (bit_cnt_ff == 4'h8) begin
                                SDA_OEN <= 1'b1;
                                state_ff <= ST_RACK;
                            end else begin
                                SDA_OEN <= shift_ff[6];
                                shift_ff <= {shift_ff[6:0], 1'b0};
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            state_ff <= sda ? ST_IDLE : ST_ACK;
                            byte_ix_ff <= ~byte_ix_ff;
                        end
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end
    wire [15:0] conf = regs_ff[{2'b00, MEAS_SEL}];
    wire [2:0] positive_input_select = conf[`CSOG_CHA_HI:`CSOG_CHA_LO];
    wire [2:0] negative_input_select = conf[`CSOG_CHB_HI:`CSOG_CHB_LO];
    wire [4:0] dac_code = conf[`CSOG_DAC_HI:`CSOG_DAC_LO]; // RULE15
    wire is_diff = (negative_input_select < `CSOG_CHB_SE_A); // RULE14
    wire is_se = (negative_input_select == `CSOG_CHB_SE_A) || (negative_input_select == `CSOG_CHB_SE_B); // RULE14
    wire dac_en = is_se && (dac_code != 5'h00); // RULE16
    wire [1:0] ch_lo = (positive_input_select[1:0] < negative_input_select[1:0]) ? positive_input_select[1:0] : negative_input_select[1:0];
    wire [1:0] ch_hi = (positive_input_select[1:0] < negative_input_select[1:0]) ? negative_input_select[1:0] : positive_input_select[1:0];
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            SHIELD1 <= 1'b0;
            SHIELD2 <= 1'b0;
            SHIELD2_OEN <= 1'b1;
            SHIELD_TIE <= 1'b0;
        end else if (is_diff) begin
            SHIELD1 <= EXC[ch_lo]; // RULE1 RULE4
            SHIELD2 <= EXC[ch_hi]; // RULE1 RULE4
            SHIELD2_OEN <= 1'b0;
            SHIELD_TIE <= 1'b0;
        end else if (dac_en) begin
            SHIELD1 <= EXC[positive_input_select[1:0]]; // RULE3 RULE4
            SHIELD2 <= 1'b0;
            SHIELD2_OEN <= 1'b1; // RULE3
            SHIELD_TIE <= 1'b0;
        end else begin
            SHIELD1 <= EXC[positive_input_select[1:0]]; // RULE2 RULE4
            SHIELD2 <= EXC[positive_input_select[1:0]]; // RULE2 RULE4
            SHIELD2_OEN <= 1'b0;
            SHIELD_TIE <= 1'b1; // RULE2
        end
    end
    wire [16:0] dac_cap = dac_code * `CSOG_DAC_STEP_FF; // RULE6
    wire [15:0] offcal = regs_ff[`CSOG_IDX_OFFCAL];
    wire signed [21:0] pos_x = {{2{CAP_POS[19]}}, CAP_POS};
    wire signed [21:0] neg_x = {{2{CAP_NEG[19]}}, CAP_NEG};
    wire signed [21:0] dac_x = {5'h00, dac_cap};
    wire signed [21:0] off_x = {{6{offcal[15]}}, offcal};
    reg signed [21:0] diff_ff;
    reg [1:0] gsel_ff;
    reg stage1_ff;
    wire signed [21:0] nxt_diff = is_diff ? (pos_x - neg_x - off_x) // RULE16
        : (dac_en ? (pos_x - dac_x - off_x) : (pos_x - off_x)); // RULE5
    wire [15:0] gain = regs_ff[`CSOG_IDX_GAIN1 + {2'b00, gsel_ff}]; // RULE17
    wire signed [38:0] prod = diff_ff * $signed({1'b0, gain});
    wire signed [38:0] scaled = prod >>> `CSOG_GAIN_SHIFT;
    wire signed [38:0] span = $signed(`CSOG_SPAN_FF);
    wire [19:0] nxt_result = (scaled > span) ? span[19:0] // RULE7
        : ((scaled < -span) ? (-span[19:0]) : scaled[19:0]); // RULE7
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            diff_ff <= 22'h00_0000;
            gsel_ff <= 2'h0;
            stage1_ff <= 1'b0;
            RESULT_VALID <= 1'b0;
            RESULT <= 20'h0_0000;
        end else begin
            stage1_ff <= CAP_VALID;
            RESULT_VALID <= stage1_ff;
            if (CAP_VALID) begin
                diff_ff <= nxt_diff;
                gsel_ff <= positive_input_select[1:0];
            end
            if (stage1_ff) begin
                RESULT <= nxt_result;
            end
        end
    end
endmodule // csog_top

/* File: tb/csog_top_assertions.sv */
// Checker for shield routing and result timing
`timescale 1ns/100ps
module csog_top_assertions (
    input wire SYS_CLK,
    input wire RSTN,
    input wire [3:0] EXC,
    input wire SHIELD1,
    input wire SHIELD2,
    input wire SHIELD2_OEN,
    input wire SHIELD_TIE,
    input wire CAP_VALID,
    input wire RESULT_VALID,
    input wire [19:0] RESULT
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    property p_res_lat;
        CAP_VALID |-> ##2 RESULT_VALID;
    endproperty
    a_res_lat: assert property (p_res_lat) else $error("result late");
    property p_res_cause;
        RESULT_VALID |-> $past(CAP_VALID, 2);
    endproperty
    a_res_cause: assert property (p_res_cause) else $error("result unasked");
    property p_res_range;
        RESULT_VALID |-> ($signed(RESULT) <= 20'sh0_3A98 && $signed(RESULT) >= -20'sh0_3A98);
    endproperty
    a_res_range: assert property (p_res_range) else $error("result out of span");
    property p_res_hold;
        !RESULT_VALID |-> $stable(RESULT);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result moved");
    property p_tie;
        SHIELD_TIE |-> (SHIELD1 == SHIELD2 && !SHIELD2_OEN);
    endproperty
    a_tie: assert property (p_tie) else $error("tied shields differ");
    property p_float;
        SHIELD2_OEN |-> (!SHIELD2 && !SHIELD_TIE);
    endproperty
    a_float: assert property (p_float) else $error("floating shield driven");
    property p_sh1;
        SHIELD1 |-> (|$past(EXC));
    endproperty
    a_sh1: assert property (p_sh1) else $error("shield one without excitation");
    property p_sh2;
        SHIELD2 |-> (|$past(EXC));
    endproperty
    a_sh2: assert property (p_sh2) else $error("shield two without excitation");
endmodule // csog_top_assertions
bind csog_top csog_top_assertions u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .EXC(EXC),
    .SHIELD1(SHIELD1), .SHIELD2(SHIELD2), .SHIELD2_OEN(SHIELD2_OEN), .SHIELD_TIE(SHIELD_TIE),
    .CAP_VALID(CAP_VALID), .RESULT_VALID(RESULT_VALID), .RESULT(RESULT));

/* File: tb/csog_host_model.sv */
// Two-wire bus host model for register access
`timescale 1ns/100ps
`include "csog_consts.vh"
module csog_host_model (
    input wire clk,
    input wire sda_oen,
    input wire sda_out,
    output reg scl,
    output wire sda
);
    reg drv = 1'b1;
    // Pulled-up wire: low if either side pulls
    assign sda = drv & (sda_oen | sda_out);
    initial scl = 1'b1;
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task bit_io(input logic b, output logic r);
        drv = b;
        wt(12);
        scl = 1'b1;
        wt(24);
        r = sda;
        scl = 1'b0;
        wt(12);
    endtask
    task start;
        drv = 1'b1;
        wt(12);
        scl = 1'b1;
        wt(24);
        drv = 1'b0;
        wt(24);
        scl = 1'b0;
        wt(12);
    endtask
    task stop;
        drv = 1'b0;
        wt(12);
        scl = 1'b1;
        wt(24);
        drv = 1'b1;
        wt(24);
    endtask
    task byte_io(input [7:0] d, input logic ha, output [7:0] q, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ha, a);
        ack = !a;
    endtask
    task wr_reg(input [7:0] p, input [15:0] v, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start;
        byte_io({`CSOG_DEV_ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(p, 1'b1, q, a1);
        byte_io(v[15:8], 1'b1, q, a2);
        byte_io(v[7:0], 1'b1, q, a3);
        stop;
        ok = a0 & a1 & a2 & a3;
    endtask
    task rd_reg(input [7:0] p, output [15:0] v);
        logic [7:0] q;
        logic a;
        start;
        byte_io({`CSOG_DEV_ADDR, 1'b0}, 1'b1, q, a);
        byte_io(p, 1'b1, q, a);
        start;
        byte_io({`CSOG_DEV_ADDR, 1'b1}, 1'b1, q, a);
        byte_io(8'hFF, 1'b0, v[15:8], a);
        byte_io(8'hFF, 1'b1, v[7:0], a);
        stop;
    endtask
endmodule // csog_host_model

/* File: tb/cap_sense_shield_offset_gain_ctrl_bench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "csog_consts.vh"
module cap_sense_shield_offset_gain_ctrl_bench;
    localparam logic [15:0] OTP = 16'h2000;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [1:0] meas_sel = 2'h0;
    reg [3:0] exc = 4'h0;
    reg cap_valid = 1'b0;
    reg [19:0] cap_pos = 20'h0_0000;
    reg [19:0] cap_neg = 20'h0_0000;
    wire scl, sda, sda_out, sda_oen, sh1, sh2, sh2_oen, tie, res_valid;
    wire [19:0] result;
    integer err_count = 0;
    integer n_compared = 0;
    always #2.5 clk = ~clk;
    csog_host_model u_host (.clk(clk), .sda_oen(sda_oen), .sda_out(sda_out), .scl(scl),
        .sda(sda));
    csog_top u_dut (.SYS_CLK(clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OEN(sda_oen), .OTP_GAIN(OTP), .MEAS_SEL(meas_sel), .EXC(exc), .SHIELD1(sh1),
        .SHIELD2(sh2), .SHIELD2_OEN(sh2_oen), .SHIELD_TIE(tie), .CAP_VALID(cap_valid),
        .CAP_POS(cap_pos), .CAP_NEG(cap_neg), .RESULT_VALID(res_valid), .RESULT(result));
    task test_done;
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk_res(input [19:0] got, input [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_reg(input [15:0] got, input [15:0] exp);
        chk_res({4'h0, got}, {4'h0, exp});
    endtask
    task chk_pin(input [3:0] got, input [3:0] exp);
        chk_res({16'h0000, got}, {16'h0000, exp});
    endtask
    task do_reset;
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (20) @(negedge clk);
    endtask
    task wr(input [7:0] p, input [15:0] v);
        logic ok;
        u_host.wr_reg(p, v, ok);
        chk_pin({3'h0, ok}, 4'h1);
    endtask
    task rd_chk(input [7:0] p, input [15:0] exp);
        logic [15:0] v;
        u_host.rd_reg(p, v);
        chk_reg(v, exp);
    endtask
    // Shield levels packed as {float, tie, shield two, shield one}
    task sh_chk(input [15:0] conf, input [3:0] e, input [3:0] exp);
        wr(8'h09, conf);
        @(negedge clk);
        meas_sel = 2'h1;
        exc = e;
        repeat (2) @(negedge clk);
        chk_pin({sh2_oen, tie, sh2, sh1}, exp);
    endtask
    task meas(input [15:0] conf, input [19:0] pos, input [19:0] neg, input [19:0] exp);
        int i;
        wr(`CSOG_REG_CONF1, conf);
        @(negedge clk);
        meas_sel = 2'h0;
        cap_pos = pos;
        cap_neg = neg;
        cap_valid = 1'b1;
        @(negedge clk);
        cap_valid = 1'b0;
        i = 0;
        while (res_valid !== 1'b1 && i < 4) begin
            @(negedge clk);
            i++;
        end
        chk_pin({res_valid, i[2:0]}, 4'h9);
        chk_res(result, exp);
    endtask
    task t_defaults;
        logic ok;
        u_host.wr_reg(8'h15, 16'h1234, ok);
        chk_pin({3'h0, ok}, 4'h0);
        rd_chk(`CSOG_REG_OFFCAL, 16'h0000);
        rd_chk(`CSOG_REG_GAIN4, OTP);
        rd_chk(`CSOG_REG_CONF4, `CSOG_CONF_RST);
        meas_sel = 2'h3;
        exc = 4'h1;
        repeat (2) @(negedge clk);
        chk_pin({sh2_oen, tie, sh2, sh1}, 4'h7);
    endtask
    task t_shields;
        sh_chk(16'h4000, 4'h4, 4'h2);
        sh_chk(16'h0800, 4'h1, 4'h1);
        sh_chk(16'h2C00, 4'h8, 4'h2);
        sh_chk(16'h3020, 4'h2, 4'h9);
        sh_chk(16'h3C00, 4'h2, 4'h7);
        sh_chk(16'h3C20, 4'hD, 4'h8);
    endtask
    task t_gains;
        for (int k = 0; k < 4; k++) wr(8'(8'h11 + k), 16'h4000 >> k);
        rd_chk(8'h13, 16'h1000);
        for (int k = 0; k < 4; k++) begin
            meas({k[2:0], 3'h4, 10'h000}, 20'h0_03E8, 20'h0_0000, 20'h0_03E8 >> k);
        end
    endtask
    task t_offset_dac;
        meas(16'h1060, 20'h0_2EE0, 20'h0_0000, 20'h0_0A41);
        meas(16'h1080, 20'h0_2EE0, 20'h0_0000, 20'hF_FE0C);
        meas(16'h13E0, 20'h1_86A0, 20'h0_0000, 20'h0_0C35);
        meas(16'h07E0, 20'h0_1388, 20'h0_03E8, 20'h0_0FA0);
        meas(16'h0400, 20'h0_4E20, 20'h0_0000, 20'h0_3A98);
        meas(16'h0400, 20'h0_0000, 20'h0_4E20, 20'hF_C568);
    endtask
    task t_reset;
        wr(`CSOG_REG_OFFCAL, 16'h03E8);
        meas(16'h1080, 20'h0_36B0, 20'h0_0000, 20'h0_01F4);
        wr(`CSOG_REG_OFFCAL, 16'h0064);
        meas(16'h1000, 20'h0_01F4, 20'h0_0000, 20'h0_0190);
        do_reset;
        rd_chk(`CSOG_REG_OFFCAL, 16'h0000);
        rd_chk(8'h12, OTP);
        meas(16'h1000, 20'h0_03E8, 20'h0_0000, 20'h0_01F4);
        wr(`CSOG_REG_OFFCAL, 16'h0064);
        meas(16'h1000, 20'h0_03E8, 20'h0_0000, 20'h0_01C2);
    endtask
    initial begin
        do_reset;
        t_defaults;
        t_shields;
        t_gains;
        t_offset_dac;
        t_reset;
        test_done;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        test_done;
    end
endmodule // cap_sense_shield_offset_gain_ctrl_bench
